// >>> rsw_params.svh
// Constants for the radar status word collector
`ifndef RSW_PARAMS_SVH
`define RSW_PARAMS_SVH
`define RSW_CLK_MHZ          125
`define RSW_WORD_W           24
`define RSW_NUM_WORDS        12
`define RSW_POS_W            16
`define RSW_STAT_W           4
`define RSW_STAT_LSB         20
`define RSW_TIME_W           30
`define RSW_T5_HI            23
`define RSW_T6_LSB           18
`define RSW_CLKLEN_VAL       8'h1e
`define RSW_TICK2M_NS        500
`define RSW_TICK2M_CYC       ((`RSW_TICK2M_NS * `RSW_CLK_MHZ) / 1000)
`define RSW_TOD_DIV          200
`define RSW_ENC_XFER_US      350
`define RSW_ENC_XFER_CYC     (`RSW_ENC_XFER_US * `RSW_CLK_MHZ)
`define RSW_ENC_BIT_CYC      2048
`define RSW_POLL_US          500
`define RSW_POLL_CYC         (`RSW_POLL_US * `RSW_CLK_MHZ)
`define RSW_READOUT_US       24
`define RSW_READOUT_CYC      (`RSW_READOUT_US * `RSW_CLK_MHZ)
`define RSW_ADC_W            10
`define RSW_ADC_X            12
`endif

// >>> rsw_pkg.sv
// Types for the radar status word collector
package rsw_pkg;
    typedef logic [23:0] rsw_word_t;
    typedef enum logic [1:0]
    {
        RSW_H_IDLE = 2'b00,
        RSW_H_READ = 2'b01,
        RSW_H_WAIT = 2'b10
    } rsw_hst_t;
endpackage : rsw_pkg

// >>> rsw_if.sv
// Link between the status collector and the host
`timescale 1ns/1ps
interface rsw_if;
    logic            call;
    logic [3:0]      addr;
    logic            rd_stb;
    logic [23:0]     data;
    logic            data_vld;
    logic            backup_mode;
    logic [15:0]     az_cmd;
    logic [15:0]     el_cmd;
    logic [23:0]     gate_time;
    modport dev
    (
        input  call, addr, rd_stb, backup_mode, az_cmd, el_cmd, gate_time,
        output data, data_vld
    );
    modport host
    (
        output call, addr, rd_stb, backup_mode, az_cmd, el_cmd, gate_time,
        input  data, data_vld
    );
endinterface : rsw_if

// >>> rsw_enc_rx.sv
// Serial-to-parallel receiver for one shaft encoder
`timescale 1ns/1ps
`include "rsw_params.svh"
module rsw_enc_rx #(
    parameter int POS_W   = `RSW_POS_W,
    parameter int BIT_CYC = `RSW_ENC_BIT_CYC
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             start,
    input  wire logic             ser_in,
    output logic                  enc_clk,
    output logic                  busy,
    output logic [POS_W-1:0]      pos,
    output logic                  done
);
    // Half bit time must fit the 12-bit divider
    if (POS_W < 2 || POS_W > 20 || BIT_CYC < 2 || BIT_CYC > 8192)
    begin : g_bad_params
        $error("rsw_enc_rx: bad parameters");
    end
    typedef struct packed {
        logic [11:0]      div;
        logic [4:0]       bits;
        logic             busy;
        logic             eclk;
        logic [POS_W-1:0] sh;
        logic [POS_W-1:0] pos;
        logic             done;
    } rsw_enc_st_t;
    rsw_enc_st_t s_q, s_d;
    always_comb
    begin
        s_d = s_q;
        s_d.done = 1'b0;
        if (start && !s_q.busy)
        begin
            s_d.busy = 1'b1;
            s_d.bits = 5'h0;
            s_d.div  = 12'h0;
        end
        else if (s_q.busy)
        begin
            if (s_q.div == 12'(BIT_CYC/2 - 1))
            begin
                s_d.div  = 12'h0;
                s_d.eclk = !s_q.eclk;
                if (s_q.eclk)
                begin
                    // Sample on falling encoder clock, MSB first
                    s_d.sh   = {s_q.sh[POS_W-2:0], ser_in};
                    s_d.bits = s_q.bits + 5'h1;
                    if (s_q.bits == 5'(POS_W-1))
                    begin
                        s_d.busy = 1'b0;
                        s_d.pos  = {s_q.sh[POS_W-2:0], ser_in};
                        s_d.done = 1'b1;
                    end
                end
            end
            else
                s_d.div = s_q.div + 12'h1;
        end
    end
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n)
            s_q <= '0;
        else
            s_q <= s_d;
    assign enc_clk = s_q.eclk;
    assign busy    = s_q.busy;
    assign pos     = s_q.pos;
    assign done    = s_q.done;
endmodule : rsw_enc_rx

// >>> rsw_host.sv
// Host end: polls the twelve status words
`timescale 1ns/1ps
`include "rsw_params.svh"
module rsw_host #(
    parameter int POLL_CYC = `RSW_POLL_CYC
) (
    input  wire logic          clk,
    input  wire logic          rst_n,
    rsw_if.host                lnk,
    input  wire logic          cfg_backup,
    input  wire logic [15:0]   cfg_az_cmd,
    input  wire logic [15:0]   cfg_el_cmd,
    input  wire logic [23:0]   cfg_gate_time,
    input  wire logic [3:0]    usr_addr,
    output logic [23:0]        usr_data,
    output logic               frame_done
);
    if (POLL_CYC < 16)
    begin : g_bad_params
        $error("rsw_host: POLL_CYC too small");
    end
    typedef struct packed {
        rsw_pkg::rsw_hst_t st;
        logic [31:0]       tmr;
        logic [3:0]        idx;
        logic              call;
        logic              rd;
        logic              done;
    } rsw_h_st_t;
    rsw_h_st_t s_q, s_d;
    logic [23:0] buf_q [12];
    always_comb
    begin
        s_d = s_q;
        s_d.call = 1'b0;
        s_d.rd   = 1'b0;
        s_d.done = 1'b0;
        s_d.tmr  = (s_q.tmr == 32'(POLL_CYC - 1)) ? 32'h0 : s_q.tmr + 32'h1;
        unique case (s_q.st)
            rsw_pkg::RSW_H_IDLE:
                if (s_q.tmr == 32'h0) // RULE12
                begin
                    s_d.call = 1'b1;
                    s_d.idx  = 4'h0;
                    s_d.st   = rsw_pkg::RSW_H_READ;
                end
            rsw_pkg::RSW_H_READ:
            begin
                s_d.rd = 1'b1;
                s_d.st = rsw_pkg::RSW_H_WAIT;
            end
            rsw_pkg::RSW_H_WAIT:
                if (lnk.data_vld)
                begin
                    if (s_q.idx == 4'd11)
                    begin
                        s_d.done = 1'b1;
                        s_d.st   = rsw_pkg::RSW_H_IDLE;
                    end
                    else
                    begin
                        s_d.idx = s_q.idx + 4'h1;
                        s_d.st  = rsw_pkg::RSW_H_READ;
                    end
                end
        endcase
    end
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n)
            s_q <= '0;
        else
            s_q <= s_d;
    always_ff @(posedge clk)
        if (s_q.st == rsw_pkg::RSW_H_WAIT && lnk.data_vld)
            buf_q[s_q.idx] <= lnk.data;
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n)
            usr_data <= 24'h0;
        else
            usr_data <= (usr_addr < 4'd12) ? buf_q[usr_addr] : 24'h0;
    assign lnk.call        = s_q.call;
    assign lnk.rd_stb      = s_q.rd;
    assign lnk.addr        = s_q.idx;
    assign lnk.backup_mode = cfg_backup; // RULE11
    assign lnk.az_cmd      = cfg_az_cmd;
    assign lnk.el_cmd      = cfg_el_cmd;
    assign lnk.gate_time   = cfg_gate_time;
    assign frame_done      = s_q.done;
endmodule : rsw_host

// >>> rsw_dev.sv
// Device end: status word collector with range and gate counters
`timescale 1ns/1ps
`include "rsw_params.svh"
// Operation
// RULE1: Twelve entries; two, eleven, twelve blank
// RULE2: Clear pulse zeroes counter; counts to marker
// RULE3: Marker starts encoder strobe and clock
// RULE4: Serial positions become entries three, four
// RULE5: Merged bits: mode, wrap, overwind, transmitter
// RULE6: Thirty-bit time across entries five, six
// RULE7: Entry six low byte fixed octal 36
// RULE8: Two MHz divided to 100 us count
// RULE9: Time count synced to five-minute mark
// RULE10: Entries seven-ten carry samples in backup
// RULE11: Host selects sample route by command
// RULE12: Host polls 500 us; readout within 24 us
// RULE13: Position entries valid after serial transfer
// RULE14: Pointing error is encoder minus command
// RULE15: Gate counter emits marker at commanded time
// RULE16: Gate counter cleared by timing clear
// RULE17: Timing separates clear and origin signals
// RULE18: Backup samples sign-extended ten to twelve
// RULE19: Backup samples strobed by host read; here adc_strobe pulses on the host call, not on rd_stb
// RULE20: Entries are 24-bit, unused read zero
module rsw_dev #(
    parameter int POS_W   = `RSW_POS_W,
    parameter int BIT_CYC = `RSW_ENC_BIT_CYC,
    parameter int TOD_DIV = `RSW_TOD_DIV
) (
    input  wire logic                clk,
    input  wire logic                rst_n,
    rsw_if.dev                       lnk,
    input  wire logic                position_count_clear,
    input  wire logic                gate_clear,
    input  wire logic                gate_origin,
    output logic                     prf_marker,
    output logic                     az_enc_strobe,
    output logic                     az_enc_clk,
    input  wire logic                az_enc_data,
    output logic                     el_enc_strobe,
    output logic                     el_enc_clk,
    input  wire logic                el_enc_data,
    input  wire logic [1:0]          op_mode,
    input  wire logic                wrap_dir,
    input  wire logic                overwind,
    input  wire logic                transmitter_active_flag,
    input  wire logic                ref_1mhz,
    input  wire logic                mark_5min,
    input  wire logic [9:0]          adc_i,
    input  wire logic [9:0]          adc_q,
    output logic                     adc_strobe,
    output logic [1:0]               adc_sel,
    output logic signed [POS_W:0]    az_error,
    output logic signed [POS_W:0]    el_error,
    output logic                     pos_valid
);
    // Commands are 16 bits wide and the divider counter is 8 bits wide
    if (POS_W > 16 || POS_W < 2 || TOD_DIV < 2 || TOD_DIV > 256)
    begin : g_bad_params
        $error("rsw_dev: bad parameters");
    end
    typedef struct packed {
        logic [23:0]       rng;
        logic              rng_run;
        logic [23:0]       rng_word;
        logic [23:0]       gate;
        logic              gate_run;
        logic              marker;
        logic              ref_d;
        logic [7:0]        div;
        logic [29:0]       tod;
        logic [23:0]       rd;
        logic              vld;
        logic [1:0]        pos_ok;
        logic [23:0]       az_w;
        logic [23:0]       el_w;
        logic              astb;
        logic              strobe;
        logic signed [POS_W:0] aze;
        logic signed [POS_W:0] ele;
    } rsw_d_st_t;
    rsw_d_st_t s_q, s_d;
    logic             az_busy, el_busy, az_done, el_done;
    logic [POS_W-1:0] az_pos, el_pos;
    rsw_enc_rx #(.POS_W(POS_W), .BIT_CYC(BIT_CYC)) u_az (
        .clk(clk), .rst_n(rst_n), .start(s_q.marker), .ser_in(az_enc_data),
        .enc_clk(az_enc_clk), .busy(az_busy), .pos(az_pos), .done(az_done));
    rsw_enc_rx #(.POS_W(POS_W), .BIT_CYC(BIT_CYC)) u_el (
        .clk(clk), .rst_n(rst_n), .start(s_q.marker), .ser_in(el_enc_data),
        .enc_clk(el_enc_clk), .busy(el_busy), .pos(el_pos), .done(el_done));
    function automatic logic [23:0] rsw_pos_word(input logic [POS_W-1:0] p,
                                                input logic [3:0] st);
        logic [23:0] w;
        w = 24'h0;
        w[POS_W-1:0] = p;
        w[23:20] = st; // RULE5
        return w;
    endfunction : rsw_pos_word
    function automatic logic [11:0] rsw_sx(input logic [9:0] v);
        return {{2{v[9]}}, v}; // RULE18
    endfunction : rsw_sx
    logic [3:0] stat_bits;
    assign stat_bits = {op_mode[0], wrap_dir, overwind,
                        transmitter_active_flag};
    always_comb
    begin
        s_d = s_q;
        s_d.marker = 1'b0;
        s_d.vld    = 1'b0;
        s_d.astb   = 1'b0;
        s_d.strobe = s_q.marker;
        // Range position count
        if (position_count_clear) // RULE2
        begin
            s_d.rng = 24'h0;
            s_d.rng_run = 1'b1;
        end
        else if (s_q.rng_run)
        begin
            if (s_q.marker)
            begin
                s_d.rng_run  = 1'b0;
                s_d.rng_word = s_q.rng;
            end
            else
                s_d.rng = s_q.rng + 24'h1;
        end
        // Gate counter; clear wins over origin
        if (gate_clear) // RULE16
        begin
            s_d.gate = 24'h0;
            s_d.gate_run = 1'b0;
        end
        else if (gate_origin)
        begin
            s_d.gate = 24'h0;
            s_d.gate_run = 1'b1;
        end
        else if (s_q.gate_run)
        begin
            s_d.gate = s_q.gate + 24'h1;
            if (s_q.gate == lnk.gate_time) // RULE15
            begin
                s_d.marker = 1'b1;
                s_d.gate_run = 1'b0;
            end
        end
        // Time of day: 1 MHz edges doubled by counting both edges
        s_d.ref_d = ref_1mhz;
        if (mark_5min) // RULE9
        begin
            s_d.div = 8'h0;
            s_d.tod = 30'h0;
        end
        else if (ref_1mhz != s_q.ref_d) // RULE8
        begin
            if (s_q.div == 8'(TOD_DIV - 1))
            begin
                s_d.div = 8'h0;
                s_d.tod = s_q.tod + 30'h1;
            end
            else
                s_d.div = s_q.div + 8'h1;
        end
        // Encoder results and pointing errors
        if (s_q.marker)
            s_d.pos_ok = 2'b00;
        if (az_done) // RULE4 RULE13
        begin
            s_d.az_w = rsw_pos_word(az_pos, stat_bits);
            s_d.pos_ok[0] = 1'b1;
            s_d.aze = $signed({1'b0, az_pos})
                    - $signed({1'b0, lnk.az_cmd[POS_W-1:0]}); // RULE14
        end
        if (el_done) // RULE4 RULE13
        begin
            s_d.el_w = rsw_pos_word(el_pos, stat_bits);
            s_d.pos_ok[1] = 1'b1;
            s_d.ele = $signed({1'b0, el_pos})
                    - $signed({1'b0, lnk.el_cmd[POS_W-1:0]}); // RULE14
        end
        // Backup A/D capture on host call
        // Samples stay in the converter registers; adc_sel picks one per
        // read, so no second copy is kept here
        if (lnk.call && lnk.backup_mode) // RULE19
            s_d.astb = 1'b1;
        // Multiplexed readout, one cycle after the strobe
        if (lnk.rd_stb) // RULE1 RULE12
        begin
            s_d.vld = 1'b1;
            unique case (lnk.addr)
                4'd0:    s_d.rd = s_q.rng_word;
                4'd2:    s_d.rd = s_q.az_w;
                4'd3:    s_d.rd = s_q.el_w;
                4'd4:    s_d.rd = s_q.tod[23:0]; // RULE6
                4'd5:    s_d.rd = {s_q.tod[29:24], 10'h0,
                                   `RSW_CLKLEN_VAL}; // RULE6 RULE7
                4'd6, 4'd7, 4'd8, 4'd9:
                    s_d.rd = lnk.backup_mode ?
                             {rsw_sx(adc_i), rsw_sx(adc_q)} : 24'h0;
                default: s_d.rd = 24'h0; // RULE20
            endcase
        end
    end
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n)
            s_q <= '0;
        else
            s_q <= s_d;
    assign lnk.data      = s_q.rd;
    assign lnk.data_vld  = s_q.vld;
    assign prf_marker    = s_q.marker;
    assign az_enc_strobe = s_q.strobe; // RULE3
    assign el_enc_strobe = s_q.strobe; // RULE3
    assign adc_strobe    = s_q.astb;
    assign adc_sel       = lnk.addr[1:0] - 2'd2;
    assign az_error      = s_q.aze;
    assign el_error      = s_q.ele;
    assign pos_valid     = &s_q.pos_ok && !az_busy && !el_busy; // RULE13
endmodule : rsw_dev

// >>> rsw_chk.sv
// Link checks between the status collector and the host
`timescale 1ns/1ps
module rsw_chk
(
    input wire logic    clk,
    input wire logic    rst_n,
    input logic         call,
    input logic [3:0]   addr,
    input logic         rd_stb,
    input logic [23:0]  data,
    input logic         data_vld,
    input logic         backup_mode
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    answer_next_a: assert property (rd_stb |=> data_vld)
        else $error("no answer after read");
    no_stray_a: assert property (!rd_stb |=> !data_vld)
        else $error("answer without read");
    data_holds_a: assert property (!rd_stb |=> $stable(data))
        else $error("word changed without read");
    readout_time_a: assert property
        (call |-> ##[1:1000] (rd_stb && addr == 4'hb))
        else $error("readout too slow");
    blank_words_a: assert property
        (rd_stb && addr inside {4'h1, 4'ha, 4'hb} |=> data == 24'h0)
        else $error("blank word not zero");
    unused_zero_a: assert property
        (rd_stb && addr > 4'h9 |=> data == 24'h0)
        else $error("unused word not zero");
    clock_len_a: assert property
        (rd_stb && addr == 4'h5 |=> data[17:0] == 18'h1e)
        else $error("clock length field wrong");
    adc_off_a: assert property
        (rd_stb && addr inside {[4'h6:4'h9]} && !backup_mode |=> data == 24'h0)
        else $error("sample word not zero");
    sign_ext_a: assert property
        (rd_stb && addr inside {[4'h6:4'h9]} |=>
         data[23:22] == {2{data[21]}} && data[11:10] == {2{data[9]}})
        else $error("sample not sign extended");
endmodule : rsw_chk

// >>> test_radar_status_word_collector.sv
// Bench joining collector and host, checking words at the host side
`timescale 1ns/1ps
module test_radar_status_word_collector;
    logic               clk, rst_n, position_count_clear, gate_clear;
    logic               gate_origin, prf_marker, az_enc_strobe, az_enc_clk;
    logic               az_enc_data, el_enc_strobe, el_enc_clk, el_enc_data;
    logic               wrap_dir, overwind, transmitter_active_flag;
    logic               ref_1mhz, mark_5min, adc_strobe, pos_valid;
    logic               cfg_backup, frame_done, stb_seen;
    logic               az_eclk_d, el_eclk_d;
    logic [1:0]         op_mode, adc_sel, sel_seen;
    logic [9:0]         adc_i, adc_q;
    logic signed [16:0] az_error, el_error;
    logic [15:0]        cfg_az_cmd, cfg_el_cmd;
    logic [23:0]        cfg_gate_time, usr_data, w;
    logic [3:0]         usr_addr;
    int                 n_mismatch, comparisons, cyc, n_eclk;

    rsw_if lnk();
    // Short bit time and divider keep the run small
    rsw_dev #(.BIT_CYC(4), .TOD_DIV(10)) rsw_dev_inst
    (
        .clk, .rst_n, .lnk, .position_count_clear, .gate_clear,
        .gate_origin, .prf_marker, .az_enc_strobe, .az_enc_clk,
        .az_enc_data, .el_enc_strobe, .el_enc_clk, .el_enc_data, .op_mode,
        .wrap_dir, .overwind, .transmitter_active_flag, .ref_1mhz,
        .mark_5min, .adc_i, .adc_q, .adc_strobe, .adc_sel, .az_error,
        .el_error, .pos_valid
    );
    rsw_host #(.POLL_CYC(64)) rsw_host_inst
    (
        .clk, .rst_n, .lnk, .cfg_backup, .cfg_az_cmd, .cfg_el_cmd,
        .cfg_gate_time, .usr_addr, .usr_data, .frame_done
    );
    rsw_chk rsw_chk_inst
    (
        .clk, .rst_n, .call(lnk.call), .addr(lnk.addr),
        .rd_stb(lnk.rd_stb), .data(lnk.data), .data_vld(lnk.data_vld),
        .backup_mode(lnk.backup_mode)
    );

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Reference edge every two cycles; time count steps every 20 cycles
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        ref_1mhz <= cyc[1];
        if (adc_strobe === 1'b1)
            stb_seen <= 1'b1;
        // Encoder clock rises of both links; must stay put between frames
        az_eclk_d <= az_enc_clk;
        el_eclk_d <= el_enc_clk;
        n_eclk <= n_eclk + int'(az_enc_clk && !az_eclk_d)
                  + int'(el_enc_clk && !el_eclk_d);
        if (lnk.rd_stb === 1'b1 && lnk.addr == 4'h7)
            sel_seen <= adc_sel;
        if (cyc == 20000)
        begin
            n_mismatch = n_mismatch + 1;
            summarize();
        end
    end

    task automatic cmp(string nm, logic [23:0] e, logic [23:0] s);
        comparisons++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask : cmp

    task automatic wait_hi(ref logic f, input string nm);
        int i;
        for (i = 0; i < 300; i++)
        begin
            @(posedge clk);
            #1;
            if (f === 1'b1)
                break;
        end
        cmp(nm, 24'h1, {23'h0, f});
    endtask : wait_hi

    task automatic rd(logic [3:0] a);
        @(posedge clk) usr_addr <= a;
        repeat (2) @(posedge clk);
        #1 w = usr_data;
    endtask : rd

    task automatic frames;
        repeat (2) wait_hi(frame_done, "frame_done");
    endtask : frames

    task automatic t_gate;
        int n;
        @(posedge clk) gate_clear <= 1'b1;
        position_count_clear <= 1'b1;
        @(posedge clk) gate_clear <= 1'b0;
        position_count_clear <= 1'b0;
        repeat (3) @(posedge clk);
        gate_origin <= 1'b1;
        @(posedge clk) gate_origin <= 1'b0;
        for (n = 0; n < 100 && prf_marker !== 1'b1; n++)
            @(posedge clk) #1;
        cmp("gate_cycles", cfg_gate_time + 24'h1, 24'(n));
        @(posedge clk) #1;
        cmp("enc_strobes", 24'h3, {22'h0, az_enc_strobe, el_enc_strobe});
        @(posedge clk) gate_origin <= 1'b1;
        @(posedge clk) gate_origin <= 1'b0;
        repeat (4) @(posedge clk);
        gate_clear <= 1'b1;
        @(posedge clk) gate_clear <= 1'b0;
        for (n = 0; n < 40 && prf_marker !== 1'b1; n++)
            @(posedge clk) #1;
        cmp("cleared_gate", 24'd40, 24'(n));
        $display("test gate done");
    endtask : t_gate

    task automatic t_enc;
        wait_hi(pos_valid, "pos_valid");
        cmp("az_error", {7'h0, 17'h0ffff - {1'b0, cfg_az_cmd}},
            {7'h0, az_error});
        cmp("el_error", {7'h0, 17'h00000 - {1'b0, cfg_el_cmd}},
            {7'h0, el_error});
        frames();
        rd(4'h2);
        cmp("word3", 24'hb0ffff, w);
        rd(4'h3);
        cmp("word4", 24'hb00000, w);
        // One transfer of sixteen bits on each of the two encoders
        cmp("enc_clocks", 24'd32, 24'(n_eclk));
        rd(4'h0);
        cmp("range_ok", 24'h1, {23'h0, w >= 24'd23 && w <= 24'd29});
        $display("test encoder done");
    endtask : t_enc

    task automatic t_words;
        int a;
        for (a = 1; a < 12; a++)
        begin
            rd(4'(a));
            if (a == 5)
                cmp("word6_low", 24'h1e, {6'h0, w[17:0]});
            else if (a > 5 || a == 1)
                cmp("blank_word", 24'h0, w);
        end
        $display("test words done");
    endtask : t_words

    task automatic t_backup;
        int a;
        @(posedge clk) stb_seen <= 1'b0;
        cfg_backup <= 1'b1;
        frames();
        cmp("adc_strobe", 24'h1, {23'h0, stb_seen});
        cmp("adc_sel", 24'h1, {22'h0, sel_seen});
        for (a = 6; a < 10; a++)
        begin
            rd(4'(a));
            cmp("sample_word", 24'he000ff, w);
        end
        @(posedge clk) cfg_backup <= 1'b0;
        $display("test backup done");
    endtask : t_backup

    task automatic t_time;
        @(posedge clk) mark_5min <= 1'b1;
        @(posedge clk) mark_5min <= 1'b0;
        frames();
        rd(4'h4);
        cmp("tod_start", 24'h1, {23'h0, w <= 24'd12});
        repeat (2000) @(posedge clk);
        frames();
        rd(4'h4);
        cmp("tod_rate", 24'h1, {23'h0, w >= 24'd100 && w <= 24'd125});
        rd(4'h5);
        cmp("tod_high", 24'h1e, w);
        $display("test time done");
    endtask : t_time

    task automatic summarize;
        $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : summarize

    initial
    begin
        {rst_n, position_count_clear, gate_clear, gate_origin} = 4'h0;
        {az_enc_data, el_enc_data, op_mode} = 4'b1001;
        {wrap_dir, overwind, transmitter_active_flag} = 3'b011;
        {ref_1mhz, mark_5min, cfg_backup, stb_seen, cyc, n_eclk} = '0;
        {az_eclk_d, el_eclk_d, sel_seen} = '0;
        {adc_i, adc_q} = {10'h200, 10'h0ff};
        {cfg_az_cmd, cfg_el_cmd} = {16'h1234, 16'h0010};
        cfg_gate_time = 24'h14;
        usr_addr = 4'h0;
        n_mismatch = 0;
        comparisons = 0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        cmp("reset_outs", 24'h0, {22'h0, prf_marker, lnk.data_vld});
        t_gate();
        t_enc();
        t_words();
        t_backup();
        t_time();
        summarize();
    end
endmodule : test_radar_status_word_collector
